/* sim/bacr_bus_partner.sv */
// behavioural external memory side: runs one bus cycle per start pulse
// assumes start is a one-cycle pulse driven off the clock edge
module bacr_bus_partner (
  input wire logic i_clk,
  input wire logic [3:0] i_len,
  input wire logic i_start,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  // ---------------------------------------------------------------
  // bus cycle length counter
  // ---------------------------------------------------------------
  // busy stays high for the whole cycle, so no new setting may land
  // plain always so the declaration start value is legal for every tool
  always @(posedge i_clk) begin
    if (i_start) cnt_q <= i_len;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign o_busy = (cnt_q != 4'h0);
endmodule

/* sim/testbench.sv */
// register bank bench: strobe port tasks plus config output compares
// assumes the partner model raises bus busy on demand
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b1;
  logic pab = 1'b0, go = 1'b0, busy, le, a2s, a3s, a5c, a6c, merr;
  logic [3:0] addr = 4'h0, glen = 4'h0;
  logic [15:0] wd = 16'h0000, rdata;
  logic [4:0] a0l, a5l, a6l, werr;
  logic [9:0] aw;
  logic [4:0] lens [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
  int fail_count = 0, num_checks = 0, n;
  bacr_bus_partner u_bacr_bus_partner (.i_clk(clk), .i_len(glen),
    .i_start(go), .o_busy(busy));
  bacr_regs u_bacr_regs (.I_CLK(clk), .I_SYS_RST(rst), .i_ADDR(addr),
    .i_WDATA(wd), .i_WR(wr), .i_RD(rd), .i_BYTE_ORDER_SELECT_PIN(pin),
    .i_PORT_AB_USED(pab), .i_BUS_BUSY(busy), .o_RDATA(rdata),
    .o_LITTLE_ENDIAN(le), .o_A0_BURST_LEN(a0l), .o_A5_BURST_LEN(a5l),
    .o_A6_BURST_LEN(a6l), .o_A2_SDRAM(a2s), .o_A3_SDRAM(a3s),
    .o_A5_CARD(a5c), .o_A6_CARD(a6c), .o_AREA_WIDTH(aw),
    .o_MTYPE_ERR(merr), .o_WIDTH_ERR(werr));
  // ---------------------------------------------------------------
  // clock and shared tasks
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle write strobe, entered just after a rising edge
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  // outputs copy stored values one edge after the write, bus idle
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(4'h0, 16'h0800);
    rdc(4'h4, 16'h3FF0);
    chk(16'(le), 16'h0001);
    chk(16'(aw), 16'h03FF);
    wrr(4'h0, 16'hFFFF);
    rdc(4'h0, 16'h0FFF);
    // areas 5 and 6 at 8 bits so every burst length below is legal
    wrr(4'h4, 16'h17F0);
    settle();
    chk(16'(aw), 16'h017F);
    for (int c = 0; c < 4; c++) begin
      wrr(4'h0, 16'(c << 9) | 16'(c << 7) | 16'(c << 5));
      settle();
      chk(16'(a0l), 16'(lens[c]));
      chk(16'(a5l), 16'(lens[c]));
      chk(16'(a6l), 16'(lens[c]));
    end
    for (int m = 0; m < 8; m++) begin
      wrr(4'h0, 16'(m << 2));
      settle();
      chk(16'({a2s, a3s, merr}), 16'({m == 3, m == 2 || m == 3,
        !(m == 0 || m == 2 || m == 3)}));
    end
    for (int k = 0; k < 4; k++) begin
      wrr(4'h0, 16'(k));
      settle();
      chk(16'({a5c, a6c}), 16'(k));
    end
    // widths: area2 00, area3 8, area4 16, area5 32, area6 8
    pab <= 1'b1;
    wrr(4'h4, 16'hDE4F);
    rdc(4'h4, 16'h1E40);
    chk(16'(aw), 16'h01E4);
    chk(16'(werr), 16'h0009);
    pab <= 1'b0;
    settle();
    settle();
    chk(16'(werr), 16'h0001);
    wrr(4'h8, 16'hFFFF);
    rdc(4'h8, 16'h0000);
    rdc(4'h4, 16'h1E40);
    // a setting written mid bus cycle must wait for the cycle to end
    glen <= 4'h6;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wrr(4'h0, 16'h0600);
    settle();
    chk(16'(a0l), 16'h0000);
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // a hung busy counts as a mismatch and skips the late compare
    if (n >= 20) begin
      fail_count++;
    end else begin
      settle();
      settle();
      chk(16'(a0l), 16'h0010);
    end
    // second power-on reset with the strap low
    pin <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(4'h0, 16'h0000);
    rdc(4'h4, 16'h3FF0);
    chk(16'({le, a0l}), 16'h0000);
    report_and_stop();
  end
endmodule

/* verilog/bacr_burst_dec.sv */
// burst code to transfer count decoder
// assumes the caller registers the result
module bacr_burst_dec (
  input wire logic [1:0] i_code,
  output logic [4:0] o_len
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // zero count means ordinary memory, no burst
  always_comb begin
    case (i_code)
      bacr_pkg::BST_4: o_len = bacr_pkg::LEN_4;
      bacr_pkg::BST_8: o_len = bacr_pkg::LEN_8;
      bacr_pkg::BST_16: o_len = bacr_pkg::LEN_16;
      default: o_len = bacr_pkg::LEN_ORD;
    endcase
  end
endmodule

/* verilog/bacr_pkg.sv */
// bus area config registers: shared constants and types
// assumes a single 100 MHz clock and a plain strobe register port
package bacr_pkg;
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] MODES_OFS = 4'h0;
  localparam logic [3:0] WIDTHS_OFS = 4'h4;
  // ---------------------------------------------------------------
  // area mode register layout
  // ---------------------------------------------------------------
  localparam int ENDIAN_BIT = 11;
  localparam int A0_BST_LO = 9;
  localparam int A5_BST_LO = 7;
  localparam int A6_BST_LO = 5;
  localparam int MTYPE_LO = 2;
  localparam int A5_CARD_BIT = 1;
  localparam int A6_CARD_BIT = 0;
  localparam logic [15:0] MODES_RST = 16'h0000;
  localparam logic [15:0] MODES_WMASK = 16'h07FF;
  // ---------------------------------------------------------------
  // area width register layout
  // ---------------------------------------------------------------
  localparam logic [15:0] WIDTHS_RST = 16'h3FF0;
  localparam logic [15:0] WIDTHS_WMASK = 16'h3FF0;
  localparam int FIRST_W_AREA = 2;
  localparam int NUM_W_AREAS = 5;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef logic [1:0] bacr_bst_t;
  localparam bacr_bst_t BST_ORD = 2'h0;
  localparam bacr_bst_t BST_4 = 2'h1;
  localparam bacr_bst_t BST_8 = 2'h2;
  localparam bacr_bst_t BST_16 = 2'h3;
  localparam logic [4:0] LEN_ORD = 5'h00;
  localparam logic [4:0] LEN_4 = 5'h04;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [2:0] MTYPE_ORD = 3'h0;
  localparam logic [2:0] MTYPE_A3 = 3'h2;
  localparam logic [2:0] MTYPE_A23 = 3'h3;
  localparam logic [1:0] WID_PROH = 2'h0;
  localparam logic [1:0] WID_32 = 2'h3;
endpackage

/* verilog/bacr_regs.sv */
// bus area configuration register bank
// assumes I_SYS_RST is the power-on reset; manual reset and standby
// never reach this block, so the registers ride through them
//
// Contract
// - bit 11 of mode register shows endian pin caught at power-on reset
// - area 0 burst code: 00 ordinary, 01/10/11 burst of 4/8/16
// - area 5 burst code at bits 8:7, 00 ordinary, else 4/8/16
// - area 6 burst code at bits 6:5, 00 ordinary, else 4/8/16
// - memory type 000 ordinary, 010 area 3 sdram, 011 both; others banned
// - bit 1 set makes area 5 card space, clear ordinary
// - bit 0 set makes area 6 card space, clear ordinary
// - width register loads 3FF0 only at power-on reset
// - width register bits 15, 14, 3:0 read zero; software writes zero
// - area n width at bits 2n+1:2n: 01 8, 10 16, 11 32, 00 banned
// - mode register clears only at power-on reset
// - endian flag is read-only and sets byte order for all areas
module bacr_regs (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] i_ADDR,
  input wire logic [15:0] i_WDATA,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic i_BYTE_ORDER_SELECT_PIN,
  input wire logic i_PORT_AB_USED,
  input wire logic i_BUS_BUSY,
  output logic [15:0] o_RDATA,
  output logic o_LITTLE_ENDIAN,
  output logic [4:0] o_A0_BURST_LEN,
  output logic [4:0] o_A5_BURST_LEN,
  output logic [4:0] o_A6_BURST_LEN,
  output logic o_A2_SDRAM,
  output logic o_A3_SDRAM,
  output logic o_A5_CARD,
  output logic o_A6_CARD,
  output logic [9:0] o_AREA_WIDTH,
  output logic o_MTYPE_ERR,
  output logic [4:0] o_WIDTH_ERR
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] modes_q;
  logic [15:0] widths_q;
  logic endian_q;
  logic [15:0] rd_d;
  logic [4:0] a0_len;
  logic [4:0] a5_len;
  logic [4:0] a6_len;
  logic [9:0] w_codes;
  logic [4:0] w_bad;
  logic hit_modes_wr;
  logic hit_widths_wr;
  logic [2:0] mtype;

  assign hit_modes_wr = i_WR && (i_ADDR == bacr_pkg::MODES_OFS);
  assign hit_widths_wr = i_WR && (i_ADDR == bacr_pkg::WIDTHS_OFS);
  assign mtype = modes_q[bacr_pkg::MTYPE_LO+2:bacr_pkg::MTYPE_LO];

  // endian pin sampled through the whole power-on reset, frozen after
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      endian_q <= i_BYTE_ORDER_SELECT_PIN;
    end
  end

  // mode register; the endian bit is never written by software
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      modes_q <= bacr_pkg::MODES_RST;
    end else if (hit_modes_wr) begin
      modes_q <= i_WDATA & bacr_pkg::MODES_WMASK;
    end
  end

  // width register; reserved bits forced to zero on write
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      widths_q <= bacr_pkg::WIDTHS_RST;
    end else if (hit_widths_wr) begin
      widths_q <= i_WDATA & bacr_pkg::WIDTHS_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // unmapped addresses read as zero
  always_comb begin
    rd_d = 16'h0000;
    if (i_RD && i_ADDR == bacr_pkg::MODES_OFS) begin
      rd_d = modes_q;
      rd_d[bacr_pkg::ENDIAN_BIT] = endian_q;
    end else if (i_RD && i_ADDR == bacr_pkg::WIDTHS_OFS) begin
      rd_d = widths_q;
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_RDATA <= 16'h0000;
    end else begin
      o_RDATA <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // decoders
  // ---------------------------------------------------------------
  bacr_burst_dec u_a0 (
    .i_code(modes_q[bacr_pkg::A0_BST_LO+1:bacr_pkg::A0_BST_LO]),
    .o_len(a0_len)
  );
  bacr_burst_dec u_a5 (
    .i_code(modes_q[bacr_pkg::A5_BST_LO+1:bacr_pkg::A5_BST_LO]),
    .o_len(a5_len)
  );
  bacr_burst_dec u_a6 (
    .i_code(modes_q[bacr_pkg::A6_BST_LO+1:bacr_pkg::A6_BST_LO]),
    .o_len(a6_len)
  );
  bacr_width_chk u_wid (
    .i_widths(widths_q),
    .i_port_ab_used(i_PORT_AB_USED),
    .o_codes(w_codes),
    .o_bad(w_bad)
  );

  // ---------------------------------------------------------------
  // active configuration seen by the bus sequencer
  // ---------------------------------------------------------------
  // copied only between cycles so a running cycle never sees a
  // half-changed setup; costs one cycle of latency after a write
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_A0_BURST_LEN <= bacr_pkg::LEN_ORD;
      o_A5_BURST_LEN <= bacr_pkg::LEN_ORD;
      o_A6_BURST_LEN <= bacr_pkg::LEN_ORD;
      o_A5_CARD <= 1'b0;
      o_A6_CARD <= 1'b0;
      o_AREA_WIDTH <= 10'h3FF;
    end else if (!i_BUS_BUSY) begin
      o_A0_BURST_LEN <= a0_len;
      o_A5_BURST_LEN <= a5_len;
      o_A6_BURST_LEN <= a6_len;
      o_A5_CARD <= modes_q[bacr_pkg::A5_CARD_BIT];
      o_A6_CARD <= modes_q[bacr_pkg::A6_CARD_BIT];
      o_AREA_WIDTH <= w_codes;
    end
  end

  // memory type; banned codes fall back to ordinary and raise a flag
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_A2_SDRAM <= 1'b0;
      o_A3_SDRAM <= 1'b0;
      o_MTYPE_ERR <= 1'b0;
    end else if (!i_BUS_BUSY) begin
      o_A2_SDRAM <= (mtype == bacr_pkg::MTYPE_A23);
      o_A3_SDRAM <= (mtype == bacr_pkg::MTYPE_A23) ||
        (mtype == bacr_pkg::MTYPE_A3);
      o_MTYPE_ERR <= (mtype != bacr_pkg::MTYPE_ORD) &&
        (mtype != bacr_pkg::MTYPE_A3) && (mtype != bacr_pkg::MTYPE_A23);
    end
  end

  // status outputs follow the stored values every cycle
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_LITTLE_ENDIAN <= 1'b0;
      o_WIDTH_ERR <= 5'h00;
    end else begin
      o_LITTLE_ENDIAN <= endian_q;
      o_WIDTH_ERR <= w_bad;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  AST_ENDIAN_RO: assert property (
    hit_modes_wr |=> $stable(endian_q) && o_LITTLE_ENDIAN == endian_q)
    else $error("endian flag moved on a write");
  AST_ENDIAN_RD: assert property (
    i_RD && i_ADDR == bacr_pkg::MODES_OFS |=>
      o_RDATA[bacr_pkg::ENDIAN_BIT] == endian_q)
    else $error("endian bit not read back");
  AST_A0_BURST16: assert property (
    modes_q[10:9] == 2'b11 && !i_BUS_BUSY |=> o_A0_BURST_LEN == 5'h10)
    else $error("area 0 burst of 16 not applied");
  AST_A5_BURST8: assert property (
    modes_q[8:7] == 2'b10 && !i_BUS_BUSY |=> o_A5_BURST_LEN == 5'h08)
    else $error("area 5 burst of 8 not applied");
  AST_A6_BURST4: assert property (
    modes_q[6:5] == 2'b01 && !i_BUS_BUSY |=> o_A6_BURST_LEN == 5'h04)
    else $error("area 6 burst of 4 not applied");
  AST_SDRAM_BOTH: assert property (
    modes_q[4:2] == 3'b011 && !i_BUS_BUSY |=> o_A2_SDRAM && o_A3_SDRAM)
    else $error("both areas not sdram");
  AST_CARD: assert property (
    !i_BUS_BUSY |=> o_A5_CARD == $past(modes_q[1]) &&
      o_A6_CARD == $past(modes_q[0]))
    else $error("card space select not applied");
  AST_RESV_ZERO: assert property (
    i_RD && i_ADDR == bacr_pkg::WIDTHS_OFS |=>
      o_RDATA[15:14] == 2'b00 && o_RDATA[3:0] == 4'h0)
    else $error("reserved width bits not zero");
  AST_WIDTH_RST: assert property (
    $fell(I_SYS_RST) |-> widths_q == 16'h3FF0 && modes_q == 16'h0000)
    else $error("register reset value wrong");
  AST_HOLD_BUSY: assert property (
    i_BUS_BUSY [*2] |-> $stable(o_A0_BURST_LEN) && $stable(o_A2_SDRAM))
    else $error("config changed inside a bus cycle");
  AST_WIDTH_BAD: assert property (
    widths_q[5:4] == 2'b00 |=> o_WIDTH_ERR[0])
    else $error("banned width code not flagged");
  AST_MODES_RD: assert property (
    i_RD && i_ADDR == bacr_pkg::MODES_OFS |=>
      o_RDATA[10:0] == $past(modes_q[10:0]) && o_RDATA[15:12] == 4'h0)
    else $error("mode register read back wrong");
  AST_MTYPE_BAN: assert property (
    o_MTYPE_ERR |-> !o_A2_SDRAM && !o_A3_SDRAM)
    else $error("banned memory type gave sdram");
  AST_WIDTH_COPY: assert property (
    !i_BUS_BUSY |=> o_AREA_WIDTH == $past(widths_q[13:4]))
    else $error("area widths not applied");
  AST_WIDTH_WR: assert property (
    hit_widths_wr |=> widths_q == ($past(i_WDATA) & 16'h3FF0))
    else $error("width register write wrong");

  COV_A0_BURST: cover property (hit_modes_wr ##[1:4] o_A0_BURST_LEN != 0);
  COV_SDRAM: cover property (o_A2_SDRAM && o_A3_SDRAM);
  COV_HOLD: cover property (hit_widths_wr && i_BUS_BUSY);
  COV_CARD: cover property (o_A5_CARD && o_A6_CARD);
endmodule

/* verilog/bacr_width_chk.sv */
// per-area bus width code checker for areas 2 to 6
// assumes width fields sit at bits 2n+1:2n of the width register
module bacr_width_chk (
  input wire logic [15:0] i_widths,
  input wire logic i_port_ab_used,
  output logic [9:0] o_codes,
  output logic [4:0] o_bad
);
  // ---------------------------------------------------------------
  // one checker per area
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < bacr_pkg::NUM_W_AREAS; g++) begin : g_area
      localparam int LO = 2 * (g + bacr_pkg::FIRST_W_AREA);
      // 32-bit is illegal only while the shared port is in use
      assign o_codes[2*g+1:2*g] = i_widths[LO+1:LO];
      assign o_bad[g] = (i_widths[LO+1:LO] == bacr_pkg::WID_PROH) ||
        (i_port_ab_used && i_widths[LO+1:LO] == bacr_pkg::WID_32);
    end
  endgenerate
endmodule
